// >>> bench/arl_host_model.sv
// arl_host_model: host side of the serial link, clocks bits out and samples the checksum pin.
// assumes the link clock idles low between frames and shift is called from a falling clk edge.
`timescale 1ns/1ps
module arl_host_model (
  // serial link
  output logic sck,
  output logic rd_bit,
  input wire logic sdo_crc_bit
);
  // link clock stands still outside frames
  initial begin
    sck = 1'b0;
    rd_bit = 1'b0;
  end

  // clock n bits msb first at 200 ns; a bit changes mid low phase so the synchronised rise,
  // taken about 110 ns after the pin rise, still sees it; the pin is sampled before each fall
  task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0000_0000;
    for (int i = n - 1; i >= 0; i--) begin
      #50;
      rd_bit = tx[i];
      #50;
      sck = 1'b1;
      #100;
      rx = {rx[30:0], sdo_crc_bit};
      sck = 1'b0;
    end
    #50;
    rd_bit = ~rd_bit; // released line must not show a stale bit
  endtask
endmodule // arl_host_model

// >>> bench/tb_arl_readout.sv
// tb_arl_readout: self-checking bench for capture, read checksum, write key and config checksum.
// assumes arl_pkg, the design and the host model are compiled first.
`timescale 1ns/1ps
module tb_arl_readout;
  import arl_pkg::*;
  // stimulus and observed signals
  logic clk, rst, modulator_clock, sck, rd_bit, rd_chan_start, wr_req;
  logic [2:0] ev, rd_chan;
  logic [NCH-1:0] conv_ready, chan_active;
  logic [NCH-1:0][DW-1:0] conv_data;
  logic [4:0] wr_addr, rd_addr;
  logic [DW-1:0] wr_data, rd_data;
  logic sdo_crc_active, sdo_crc_bit, wr_done, data_ready_pin_n, config_alarm;
  logic [31:0] v, rx;
  int err_total, samples_checked;
  localparam logic [23:0] MODE_CFG [3] = '{24'h00_0300, 24'h00_0700, 24'h00_0100};
  localparam int MODE_BITS [3] = '{16, 32, 0};

  arl_readout u_arl_readout (
    .clk(clk), .rst(rst), .modulator_clock(modulator_clock), .sck(sck),
    .conv_ready(conv_ready), .conv_data(conv_data), .chan_active(chan_active),
    .rd_seq_start(ev[0]), .rd_seq_end(ev[1]), .rd_chan_start(rd_chan_start), .rd_chan(rd_chan),
    .rd_bit(rd_bit), .rd_set_done(ev[2]), .sdo_crc_active(sdo_crc_active), .sdo_crc_bit(sdo_crc_bit),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_done(wr_done), .rd_addr(rd_addr),
    .rd_data(rd_data), .data_ready_pin_n(data_ready_pin_n), .config_alarm(config_alarm)
  );
  arl_host_model u_arl_host_model (.sck(sck), .rd_bit(rd_bit), .sdo_crc_bit(sdo_crc_bit));

  // system clock 40 MHz and free-running modulator clock 2 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    modulator_clock = 1'b0;
    forever #250 modulator_clock = ~modulator_clock;
  end

  // verdict and counts
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // a bounded wait that ran out ends the run
  task automatic bail(input logic hit);
    if (hit) begin
      err_total++;
      complete_run;
    end
  endtask

  // reference checksum over the n low bits of w, msb first
  function automatic logic [15:0] crcb(input logic [15:0] c, input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h8005 : 16'h0000);
    end
    return c;
  endfunction

  // register access and event strobes
  task automatic wr(input logic [4:0] a, input logic [23:0] d, input logic ok);
    logic seen;
    wr_addr = a;
    wr_data = d;
    wr_req = 1'b1;
    @(negedge clk);
    wr_req = 1'b0;
    seen = wr_done;
    @(negedge clk);
    seen = seen | wr_done;
    chk("wr_done", seen, ok);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    rd_addr = a;
    repeat (2) @(negedge clk);
    q = {8'h00, rd_data};
  endtask

  task automatic ev_pulse(input logic [2:0] m);
    ev = m;
    @(negedge clk);
    ev = 3'h0;
    @(negedge clk);
  endtask

  task automatic frz(input logic [2:0] ch);
    rd_chan = ch;
    rd_chan_start = 1'b1;
    @(negedge clk);
    rd_chan_start = 1'b0;
    @(negedge clk);
  endtask

  task automatic cap(input logic [5:0] m, input logic [23:0] base);
    @(posedge modulator_clock);
    @(negedge clk);
    for (int i = 0; i < NCH; i++) conv_data[i] = base + 24'(i);
    conv_ready = m;
    @(negedge clk);
    conv_ready = 6'h00;
  endtask

  // reset state of pins and registers
  task automatic t_reset;
    chk("pin", data_ready_pin_n, 1'b1);
    chk("alarm", config_alarm, 1'b0);
    chk("crc_act", sdo_crc_active, 1'b0);
    rd(ADDR_STATUS, v);
    chk("status", v, 32'h0000_013F);
    rd(ADDR_KEY, v);
    chk("key", v, 32'h00A5_0000);
    $display("reset test done");
  endtask

  // lock, refused writes and config checksum
  task automatic t_lock;
    logic [15:0] c;
    logic [31:0] w;
    wr(5'h09, 24'h12_3456, 1'b1);
    wr(5'h00, 24'h11_1111, 1'b0);
    wr(ADDR_STATUS, 24'h00_0900, 1'b1);
    wr(ADDR_KEY, 24'h00_0000, 1'b1);
    wr(ADDR_KEY, 24'h5A_0000, 1'b1);
    wr(5'h09, 24'hFF_FFFF, 1'b0);
    rd(5'h09, v);
    chk("cfg9", v, 32'h0012_3456);
    repeat (45) @(posedge modulator_clock);
    @(negedge clk);
    c = 16'h0000;
    for (int a = 9; a < 32; a++) begin
      w = (a == 9) ? 32'h0012_3456 : (a == 12) ? 32'h0000_093F : (a == 31) ? 32'h005A_0000 : 32'h0000_0000;
      c = crcb(c, w, 24);
    end
    rd(ADDR_KEY, v);
    chk("cfg_crc", v, {8'h00, 8'h5A, c});
    chk("alarm", config_alarm, 1'b0);
    chk("pin", data_ready_pin_n, 1'b1);
    wr(ADDR_KEY, 24'hA5_0000, 1'b1);
    rd(ADDR_KEY, v);
    chk("cfg_crc_clr", v, 32'h00A5_0000);
    wr(5'h09, 24'h00_0000, 1'b1);
    $display("lock test done");
  endtask

  // two latch stages, linked and unlinked capture, data ready pulse
  task automatic t_capture;
    int n;
    cap(6'h3F, 24'h10_0000);
    for (n = 0; n < 6 && data_ready_pin_n !== 1'b0; n++) @(negedge clk);
    bail(n == 6);
    for (n = 0; n < 40 && data_ready_pin_n === 1'b0; n++) @(negedge clk);
    bail(n == 40);
    chk("dr_width", n >= 6 && n <= 16, 1'b1);
    rd(ADDR_STATUS, v);
    chk("flags", v[5:0], 6'h00);
    ev_pulse(3'h1);
    frz(3'h0);
    rd(5'h00, v);
    chk("ch0", v, 32'h0010_0000);
    rd(ADDR_STATUS, v);
    chk("flag0", v[5:0], 6'h01);
    cap(6'h3F, 24'h20_0000);
    rd(5'h00, v);
    chk("ch0_hold", v, 32'h0010_0000);
    frz(3'h0);
    rd(5'h00, v);
    chk("ch0_new", v, 32'h0020_0000);
    cap(6'h02, 24'h30_0000);
    frz(3'h1);
    rd(5'h01, v);
    chk("ch1_linked", v, 32'h0020_0001);
    wr(ADDR_STATUS, 24'h00_0000, 1'b1);
    cap(6'h02, 24'h40_0000);
    frz(3'h1);
    rd(5'h01, v);
    chk("ch1_alone", v, 32'h0040_0001);
    wr(ADDR_STATUS, 24'h00_0100, 1'b1);
    chan_active = 6'h02;
    cap(6'h03, 24'h50_0000);
    frz(3'h1);
    rd(5'h01, v);
    chk("ch1_only", v, 32'h0050_0001);
    frz(3'h0);
    rd(5'h00, v);
    chk("ch0_idle", v, 32'h0020_0000);
    chan_active = 6'h3F;
    ev_pulse(3'h2);
    $display("capture test done");
  endtask

  // read checksum in 16-bit, 32-bit and disabled modes
  task automatic t_crc;
    logic [15:0] c;
    logic [23:0] w;
    ev_pulse(3'h1);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_STATUS, MODE_CFG[m], 1'b1);
      w = 24'hC0_FFEE + 24'(m);
      u_arl_host_model.shift({8'h00, w}, 24, rx);
      repeat (3) @(negedge clk);
      chk("crc_early", sdo_crc_active, 1'b0);
      ev_pulse(3'h4);
      c = crcb(16'h0000, {8'h00, w}, 24);
      chk("crc_act", sdo_crc_active, MODE_BITS[m] != 0);
      if (MODE_BITS[m] != 0) begin
        u_arl_host_model.shift(32'h0000_0000, MODE_BITS[m], rx);
        chk("crc", rx, (MODE_BITS[m] == 16) ? {16'h0000, c} : {c, 16'h0000});
        chk("residue", crcb(c, rx, MODE_BITS[m]), 16'h0000);
      end
      repeat (8) @(negedge clk);
      chk("crc_idle", sdo_crc_active, 1'b0);
    end
    ev_pulse(3'h2);
    $display("checksum test done");
  endtask

  // hang guard
  initial begin
    repeat (80000) @(posedge clk);
    bail(1'b1);
  end

  // main sequence
  initial begin
    rst = 1'b1;
    ev = 3'h0;
    rd_chan = 3'h0;
    rd_chan_start = 1'b0;
    conv_ready = 6'h00;
    conv_data = '0;
    chan_active = 6'h3F;
    wr_req = 1'b0;
    wr_addr = 5'h00;
    wr_data = 24'h00_0000;
    rd_addr = 5'h00;
    err_total = 0;
    samples_checked = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    t_reset;
    t_lock;
    t_capture;
    t_crc;
    complete_run;
  end
endmodule // tb_arl_readout

// >>> hw/arl_crc16.sv
// arl_crc16: serial 16-bit checksum register for the outgoing read stream.
// assumes shift pulses come one per transmitted bit from the same clock.
`timescale 1ns/1ps
module arl_crc16 (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control and result
  arl_crc_if.engine crc
);
  import arl_pkg::*;

  typedef struct packed {
    logic [15:0] v;
  } arl_crc_st_t;

  arl_crc_st_t st_reg;
  arl_crc_st_t st_next;

  // clear takes priority so a new sequence always starts from zero
  always_comb begin
    st_next = st_reg;
    if (crc.clear) begin
      st_next.v = CRC_ZERO;
    end else if (crc.shift) begin
      st_next.v = crc16_step(st_reg.v, crc.din);
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign crc.value = st_reg.v;
endmodule // arl_crc16

// >>> hw/arl_crc_if.sv
// arl_crc_if: control and result of the serial read checksum engine.
// assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface arl_crc_if;
  logic clear;
  logic shift;
  logic din;
  logic [15:0] value;
  modport engine (input clear, input shift, input din, output value);
  modport user (output clear, output shift, output din, input value);
endinterface

// >>> hw/arl_pin_sync.sv
// arl_pin_sync: three-stage synchroniser with edge pulses for a slow outside clock pin.
// assumes the pin stays at each level for several cycles of clk.
`timescale 1ns/1ps
module arl_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and results
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic [2:0] ff;
    logic lvl;
    logic rise;
    logic fall;
  } arl_sync_st_t;

  arl_sync_st_t st_reg;
  arl_sync_st_t st_next;

  // a change counts once the second and third stages agree
  always_comb begin
    st_next = st_reg;
    st_next.ff = {st_reg.ff[1:0], pin};
    if (st_reg.ff[1] == st_reg.ff[2]) begin
      st_next.lvl = st_reg.ff[2];
    end
    st_next.rise = st_next.lvl & ~st_reg.lvl;
    st_next.fall = ~st_next.lvl & st_reg.lvl;
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.lvl;
  assign rise = st_reg.rise;
  assign fall = st_reg.fall;
endmodule // arl_pin_sync

// >>> hw/arl_pkg.sv
// arl_pkg: shared constants, field positions and checksum functions for the readout integrity block.
// assumes a 5-bit register address space with 24-bit register words.
package arl_pkg;
  localparam int NCH = 6;
  localparam int DW = 24;
  localparam int NCFG = 22; // stored words 0x09..0x1e
  localparam int NCFGW = 23; // words covered by the config checksum, 0x09..0x1f
  localparam logic [4:0] ADDR_CH_LAST = 5'h05;
  localparam logic [4:0] ADDR_CFG_FIRST = 5'h09;
  localparam logic [4:0] ADDR_STATUS = 5'h0C;
  localparam logic [4:0] ADDR_CFG_LAST = 5'h1E;
  localparam logic [4:0] ADDR_KEY = 5'h1F;
  localparam logic [4:0] STAT_IDX = ADDR_STATUS - ADDR_CFG_FIRST;
  // status word fields
  localparam int STAT_READY_LSB = 0;
  localparam int STAT_LINK_BIT = 8;
  localparam int STAT_CRC_EN_BIT = 9;
  localparam int STAT_CRC_W32_BIT = 10;
  localparam int STAT_ALARM_EN_BIT = 11;
  localparam logic [23:0] STATUS_RST = 24'h00_013F;
  localparam logic [23:0] CFG_RST = 24'h00_0000;
  // key and checksum fields of the last word
  localparam int KEY_LSB = 16;
  localparam logic [7:0] KEY_OPEN = 8'hA5;
  localparam logic [7:0] KEY_RST = 8'hA5;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_ZERO = 16'h0000;
  // config checksum pacing in modulator clock periods, read checksum lengths in bits
  localparam int CFG_TICKS = 21;
  localparam logic [4:0] CFG_LAST_TICK = 5'(CFG_TICKS - 1);
  localparam logic [5:0] CRC_BITS16 = 6'd16;
  localparam logic [5:0] CRC_BITS32 = 6'd32;

  // one message bit into the 0x8005 checksum, msb first
  function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[15] ^ b;
    crc16_step = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : CRC_ZERO);
  endfunction

  // a whole 24-bit word, msb first
  function automatic logic [15:0] crc16_word(input logic [15:0] c, input logic [DW-1:0] w);
    logic [15:0] r;
    r = c;
    for (int i = DW - 1; i >= 0; i--) begin
      r = crc16_step(r, w[i]);
    end
    crc16_word = r;
  endfunction
endpackage

// >>> hw/arl_readout.sv
// arl_readout: double-buffered channel results, read stream checksum, write key and config checksum alarm.
// assumes framing logic on clk supplies sequence and channel read events and the register access strobes.
`timescale 1ns/1ps
module arl_readout (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // outside clock pins
  input wire logic modulator_clock,
  input wire logic sck,
  // converter results
  input wire logic [arl_pkg::NCH-1:0] conv_ready,
  input wire logic [arl_pkg::NCH-1:0][arl_pkg::DW-1:0] conv_data,
  input wire logic [arl_pkg::NCH-1:0] chan_active,
  // read framing events
  input wire logic rd_seq_start,
  input wire logic rd_seq_end,
  input wire logic rd_chan_start,
  input wire logic [2:0] rd_chan,
  input wire logic rd_bit,
  input wire logic rd_set_done,
  // checksum on the data output
  output logic sdo_crc_active,
  output logic sdo_crc_bit,
  // register access
  input wire logic wr_req,
  input wire logic [4:0] wr_addr,
  input wire logic [arl_pkg::DW-1:0] wr_data,
  output logic wr_done,
  input wire logic [4:0] rd_addr,
  output logic [arl_pkg::DW-1:0] rd_data,
  // pins and state
  output logic data_ready_pin_n,
  output logic config_alarm
);
  import arl_pkg::*;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_RUN = 3'b010,
    SEQ_CRC = 3'b100
  } arl_seq_t;

  typedef struct packed {
    arl_seq_t seq;
    logic [NCH-1:0][DW-1:0] stage1;
    logic [NCH-1:0][DW-1:0] stage2;
    logic [NCH-1:0] ready_n;
    logic [NCH-1:0] pend;
    logic [NCFG-1:0][DW-1:0] cfg;
    logic [7:0] key;
    logic [15:0] cfg_crc;
    logic [15:0] acc;
    logic [15:0] ref_crc;
    logic ref_ok;
    logic alarm;
    logic [4:0] tick;
    logic dr_low;
    logic dr_n;
    logic [31:0] crc_sr;
    logic [5:0] crc_cnt;
    logic [DW-1:0] rd_data;
    logic wr_done;
  } arl_st_t;

  arl_st_t st_reg;
  arl_st_t st_next;
  arl_crc_if crc_bus ();
  logic dm_rise;
  logic dm_fall;
  logic sck_rise;
  logic sck_fall;
  logic [NCH-1:0] cap;
  logic locked;
  logic wr_ok;

  // word j of the checksum message, flags forced to ones and checksum field to zeros
  function automatic logic [DW-1:0] cfg_word(input arl_st_t s, input logic [4:0] j);
    logic [DW-1:0] w;
    w = '0;
    if (j == 5'(NCFG)) begin
      w = {s.key, CRC_ZERO};
    end else begin
      w = s.cfg[j];
      if (j == STAT_IDX) begin
        w[STAT_READY_LSB +: NCH] = '1;
      end
    end
    cfg_word = w;
  endfunction

  // pin synchronisers for the two outside clocks
  arl_pin_sync u_dm_sync (
    .clk(clk),
    .rst(rst),
    .pin(modulator_clock),
    .level(),
    .rise(dm_rise),
    .fall(dm_fall)
  );

  arl_pin_sync u_sck_sync (
    .clk(clk),
    .rst(rst),
    .pin(sck),
    .level(),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  // serial checksum of the outgoing read stream
  arl_crc16 u_crc (
    .clk(clk),
    .rst(rst),
    .crc(crc_bus)
  );

  assign locked = st_reg.key != KEY_OPEN;
  assign wr_ok = wr_req && wr_addr >= ADDR_CFG_FIRST && (!locked || wr_addr == ADDR_KEY);

  // first latch stage capture set, joined across active channels when linked
  always_comb begin
    logic [NCH-1:0] seen;
    seen = (st_reg.pend | conv_ready) & chan_active;
    cap = '0;
    if (st_reg.cfg[STAT_IDX][STAT_LINK_BIT]) begin
      if (chan_active != '0 && seen == chan_active) begin
        cap = chan_active;
      end
    end else begin
      cap = conv_ready & chan_active;
    end
  end

  // read checksum engine controls
  assign crc_bus.din = rd_bit;
  assign crc_bus.shift = st_reg.seq == SEQ_RUN && sck_rise;
  assign crc_bus.clear = rd_seq_start || (st_reg.seq == SEQ_CRC && sck_fall && st_reg.crc_cnt == 6'd1)
    || (st_reg.seq == SEQ_RUN && rd_set_done && !st_reg.cfg[STAT_IDX][STAT_CRC_EN_BIT]);

  // next state of the whole block
  always_comb begin
    logic [15:0] res;
    logic [4:0] j;
    res = '0;
    j = '0;
    st_next = st_reg;
    st_next.wr_done = wr_ok;
    // first stage latches, ready flag cleared on capture
    for (int i = 0; i < NCH; i++) begin
      if (cap[i]) begin
        st_next.stage1[i] = conv_data[i];
      end
    end
    st_next.pend = (st_reg.cfg[STAT_IDX][STAT_LINK_BIT] && cap == '0) ? (st_reg.pend | conv_ready) & chan_active : '0;
    // second stage freezes the channel whose read begins
    if (rd_chan_start && rd_chan <= 3'(ADDR_CH_LAST)) begin
      st_next.stage2[rd_chan] = st_reg.stage1[rd_chan];
      st_next.ready_n[rd_chan] = 1'b1;
    end
    st_next.ready_n = st_next.ready_n & ~cap; // capture wins over a read in the same cycle
    // data ready pulse: low from the capture to the next modulator falling edge
    if (cap != '0) begin
      st_next.dr_low = 1'b1;
    end else if (dm_fall) begin
      st_next.dr_low = 1'b0;
    end
    st_next.dr_n = !(st_reg.dr_low || st_reg.alarm);
    // register writes
    if (wr_ok) begin
      if (wr_addr == ADDR_KEY) begin
        st_next.key = wr_data[KEY_LSB +: 8];
      end else begin
        st_next.cfg[5'(wr_addr - ADDR_CFG_FIRST)] = wr_data;
      end
    end
    // config checksum, one word per modulator period, last three words together
    if (!locked) begin
      st_next.tick = '0;
      st_next.acc = CRC_ZERO;
      st_next.cfg_crc = CRC_ZERO;
      st_next.ref_ok = 1'b0;
      st_next.alarm = 1'b0;
    end else if (wr_ok) begin
      st_next.tick = '0;
      st_next.acc = CRC_ZERO;
      st_next.ref_ok = 1'b0;
    end else if (dm_rise) begin
      if (st_reg.tick == CFG_LAST_TICK) begin
        res = crc16_word(st_reg.acc, cfg_word(st_reg, CFG_LAST_TICK));
        res = crc16_word(res, cfg_word(st_reg, 5'(NCFG - 1)));
        res = crc16_word(res, cfg_word(st_reg, 5'(NCFG)));
        st_next.cfg_crc = res;
        st_next.acc = CRC_ZERO;
        st_next.tick = '0;
        if (!st_reg.ref_ok) begin
          st_next.ref_crc = res;
          st_next.ref_ok = 1'b1;
        end else if (res != st_reg.ref_crc && st_reg.cfg[STAT_IDX][STAT_ALARM_EN_BIT]) begin
          st_next.alarm = 1'b1;
        end
      end else begin
        j = st_reg.tick;
        st_next.acc = crc16_word(st_reg.acc, cfg_word(st_reg, j));
        st_next.tick = st_reg.tick + 5'd1;
      end
    end
    // read sequence and checksum framing
    unique case (st_reg.seq)
      SEQ_IDLE: begin
        if (rd_seq_start) begin
          st_next.seq = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (rd_set_done && st_reg.cfg[STAT_IDX][STAT_CRC_EN_BIT]) begin
          st_next.seq = SEQ_CRC;
          st_next.crc_sr = {crc_bus.value, CRC_ZERO};
          st_next.crc_cnt = st_reg.cfg[STAT_IDX][STAT_CRC_W32_BIT] ? CRC_BITS32 : CRC_BITS16;
        end
      end
      SEQ_CRC: begin
        if (sck_fall) begin
          st_next.crc_sr = {st_reg.crc_sr[30:0], 1'b0};
          st_next.crc_cnt = st_reg.crc_cnt - 6'd1;
          if (st_reg.crc_cnt == 6'd1) begin
            st_next.seq = SEQ_RUN;
          end
        end
      end
    endcase
    if (rd_seq_end) begin
      st_next.seq = SEQ_IDLE;
    end
    // registered read data
    st_next.rd_data = '0;
    if (rd_addr <= ADDR_CH_LAST) begin
      st_next.rd_data = st_reg.stage2[rd_addr];
    end else if (rd_addr == ADDR_KEY) begin
      st_next.rd_data = {st_reg.key, st_reg.cfg_crc};
    end else if (rd_addr >= ADDR_CFG_FIRST) begin
      st_next.rd_data = st_reg.cfg[5'(rd_addr - ADDR_CFG_FIRST)];
      if (rd_addr == ADDR_STATUS) begin
        st_next.rd_data[STAT_READY_LSB +: NCH] = st_reg.ready_n;
      end
    end
  end

  // state register; key open and alarm clear from reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.seq <= SEQ_IDLE;
      st_reg.ready_n <= '1;
      st_reg.key <= KEY_RST;
      st_reg.cfg_crc <= CRC_ZERO;
      st_reg.alarm <= 1'b0;
      st_reg.dr_n <= 1'b1;
      for (int i = 0; i < NCFG; i++) begin
        st_reg.cfg[i] <= (i == int'(STAT_IDX)) ? STATUS_RST : CFG_RST;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  assign sdo_crc_active = st_reg.seq == SEQ_CRC;
  assign sdo_crc_bit = st_reg.crc_sr[31];
  assign wr_done = st_reg.wr_done;
  assign rd_data = st_reg.rd_data;
  assign data_ready_pin_n = st_reg.dr_n;
  assign config_alarm = st_reg.alarm;

  // checks
  capture_data_a: assert property (@(posedge clk) disable iff (rst)
    cap[0] |=> st_reg.stage1[0] == $past(conv_data[0]) && !st_reg.ready_n[0])
    else $error("channel capture missed");
  read_freeze_a: assert property (@(posedge clk) disable iff (rst)
    rd_chan_start && rd_chan == 3'd0 |=> st_reg.stage2[0] == $past(st_reg.stage1[0]))
    else $error("read freeze missed");
  locked_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_req && locked && wr_addr != ADDR_KEY |=> $stable(st_reg.cfg) && !wr_done)
    else $error("write taken while locked");
  key_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_req && wr_addr == ADDR_KEY |=> st_reg.key == $past(wr_data[KEY_LSB +: 8]))
    else $error("key write lost");
  unlocked_crc_a: assert property (@(posedge clk) disable iff (rst)
    !locked && $past(!locked) |-> st_reg.cfg_crc == CRC_ZERO && st_reg.tick == 5'd0)
    else $error("config checksum active while unlocked");
  tick_range_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.tick <= CFG_LAST_TICK and (dm_rise && locked && !wr_ok && st_reg.tick == 5'd3 |=> st_reg.tick == 5'd4))
    else $error("config checksum pacing wrong");
  crc_frame_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.seq == SEQ_RUN && rd_set_done && !rd_seq_end && st_reg.cfg[STAT_IDX][STAT_CRC_EN_BIT]
    |=> st_reg.seq == SEQ_CRC && st_reg.crc_sr[31:16] == $past(crc_bus.value)
    && st_reg.crc_cnt == ($past(st_reg.cfg[STAT_IDX][STAT_CRC_W32_BIT]) ? CRC_BITS32 : CRC_BITS16))
    else $error("checksum framing wrong");
  no_crc_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.seq == SEQ_RUN && !st_reg.cfg[STAT_IDX][STAT_CRC_EN_BIT] |=> st_reg.seq != SEQ_CRC)
    else $error("checksum sent while disabled");
  alarm_pin_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.alarm |=> !data_ready_pin_n)
    else $error("alarm not on pin");
  alarm_hold_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.alarm && locked |=> st_reg.alarm)
    else $error("alarm dropped while locked");
  unlock_clear_a: assert property (@(posedge clk) disable iff (rst)
    !locked |=> !st_reg.alarm)
    else $error("alarm kept after unlock");
  dr_pulse_a: assert property (@(posedge clk) disable iff (rst)
    cap != '0 |=> ##1 !data_ready_pin_n)
    else $error("data ready pulse missing");
endmodule // arl_readout
